/* include/dif_map.svh */
// Register map, field positions, reset values and timing counts
`ifndef DIF_MAP_SVH
`define DIF_MAP_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define DIF_CTRL 8'h00
`define DIF_PCFG 8'h04
`define DIF_PMAX 8'h08
`define DIF_CNTV 8'h0c
`define DIF_AFUN 8'h10
`define DIF_AMIN 8'h14
`define DIF_AMAX 8'h18
`define DIF_WOBD 8'h1c
`define DIF_CATP 8'h20
`define DIF_REFH 8'h24
`define DIF_FRQH 8'h28
`define DIF_STAT 8'h2c
`define DIF_AOUT 8'h30
`define DIF_POUT 8'h34
// ****************************************
// Control fields and reset values
// ****************************************
`define DIF_B_FRZREF 0
`define DIF_B_FRZOUT 1
`define DIF_B_MULTI 2
`define DIF_B_EXTPRE 3
`define DIF_RST_AMAX 16'h2710
`define DIF_RST_PMAX 16'h03e8
`define DIF_REF_MAX 16'h03e8
// ****************************************
// Digital input pin positions
// ****************************************
`define DIF_NIN 18
// Idle pin levels: stop-type pins and the accurate halt pin rest high
`define DIF_IN_IDLE 18'h0100f
`define DIF_IN_COAST 0
`define DIF_IN_QUICK 1
`define DIF_IN_DCBRK 2
`define DIF_IN_STOP 3
`define DIF_IN_INC 4
`define DIF_IN_DEC 5
`define DIF_IN_CATCH 6
`define DIF_IN_SLOW 7
`define DIF_IN_RAMP 8
`define DIF_IN_PLSB 9
`define DIF_IN_PMSB 10
`define DIF_IN_PON 11
`define DIF_IN_HALT 12
`define DIF_IN_SLSB 13
`define DIF_IN_SMSB 14
`define DIF_IN_RSTART 15
`define DIF_IN_TRKA 16
`define DIF_IN_TRKB 17
// ****************************************
// Timing
// ****************************************
`define DIF_CLK_HZ 32'h00989680
`define DIF_MS_PER_S 32'h000003e8
`define DIF_PULSE_MIN_MS 5'h0e
`define DIF_GATE_MS 8'h64
`define DIF_HZ_PER_GATE (`DIF_MS_PER_S / 32'h00000064)
`endif

/* include/dif_pkg.sv */
// Types shared by the input function decoder
package dif_pkg;
   typedef enum logic [3:0] {
      DIF_AIN_OFF = 4'h0,
      DIF_AIN_REF = 4'h1,
      DIF_AIN_FB = 4'h2,
      DIF_AIN_WOB = 4'ha
   } dif_ain_t;
   typedef enum logic [2:0] {
      DIF_P_OFF = 3'h0,
      DIF_P_PREF = 3'h1,
      DIF_P_PFB = 3'h2,
      DIF_P_PCNT = 3'h3,
      DIF_P_EREF = 3'h4,
      DIF_P_EFB = 3'h5,
      DIF_P_ECNT = 3'h6
   } dif_pfun_t;
   typedef enum logic [1:0] {
      DIF_D_IDLE = 2'b00,
      DIF_D_RUN = 2'b01,
      DIF_D_DONE = 2'b10
   } dif_div_t;
endpackage

/* rtl/dif_decoder.sv */
// Digital input function decoder with analogue input scaling
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "dif_map.svh"
//
// Function
// - Output-frequency hold blocks ordinary stop; coast, quick, DC-brake still act.
// - Up/down inputs act only while a hold function is selected.
// - Increment raises, decrement lowers; both together lowers.
// - Up/down frequency changes use the second ramp set.
// - Up/down pulse needs 14 ms high, 14 ms low; step 0.1 % or 0.1 Hz.
// - Held reference changes while stopped and survives mains loss; here reset clears refHeld and software reloads it.
// - Catch-up adds, slow-down subtracts programmed percent; both means subtract.
// - Ramp input low picks ramp set one, high picks set two.
// - Two preset bits form binary index for presets one to four.
// - Preset-enable picks preset over remote only in external/preset mode.
// - Pulse/encoder reference maps 0 Hz to min, max pulse to max.
// - Pulse/encoder feedback takes max pulse frequency as full scale.
// - Count mode counts pulses and starts precise stop at counter value.
// - Accurate halt input low ramps motor down on selected ramp.
// - Setup bits pick one of four setups only in multi-setup.
// - Reset-and-start clears alarm and ramps up to preset reference.
// - Encoder modes decode quadrature with direction, A on first input.
// - Voltage input code 0 ignore, 1 reference, 2 feedback, 10 wobble.
// - Several reference sources are added together.
// - Wobble mode: full input equals configured wobble delta.
// - Voltage input maps linearly from min scaling to max scaling.
module dif_decoder #(
   parameter int unsigned MS_CYCLES = `DIF_CLK_HZ / `DIF_MS_PER_S
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [17:0] dIn,
   input wire logic [13:0] ainMv,
   output logic coastCmd,
   output logic quickCmd,
   output logic dcBrakeCmd,
   output logic rampStopCmd,
   output logic rampSet2,
   output logic [1:0] presetIdx,
   output logic usePreset,
   output logic [1:0] setupIdx,
   output logic alarmReset,
   output logic runPreset,
   output logic [15:0] refHeld,
   output logic [15:0] freqHeld,
   output logic signed [8:0] refTrim,
   output logic [16:0] refSum,
   output logic [15:0] feedback,
   output logic [15:0] wobbleOut
);
   localparam logic [13:0] MS_LAST = 14'(MS_CYCLES - 1);
   localparam logic [4:0] THR = `DIF_PULSE_MIN_MS;
   localparam logic [15:0] HZ_MUL = 16'(`DIF_HZ_PER_GATE);

   function automatic logic [15:0] sat16(input logic [16:0] v);
      sat16 = v[16] ? 16'hffff : v[15:0];
   endfunction

   // ****************************************
   // APB registers
   // ****************************************
   logic [3:0] ctrl_reg;
   dif_pkg::dif_pfun_t pfun_reg;
   dif_pkg::dif_ain_t afun_reg;
   logic [15:0] pMax_reg, cntVal_reg, aMin_reg, aMax_reg, wobD_reg;
   logic [7:0] catPct_reg;
   logic cntHalt_reg, haltReq;
   logic signed [15:0] posCnt_reg;
   logic [15:0] ainFrac_reg, pulseFrac_reg;
   wire access = psel & penable;
   wire wrEn = access & pwrite & pready;
   wire frzRef = ctrl_reg[`DIF_B_FRZREF];
   wire frzOut = ctrl_reg[`DIF_B_FRZOUT];
   wire mapped = paddr[1:0] == 2'b00 && paddr <= `DIF_POUT;
   wire refWr = wrEn && paddr == `DIF_REFH;
   wire frqWr = wrEn && paddr == `DIF_FRQH;
   wire cntWr = wrEn && paddr == `DIF_CNTV;
   logic [31:0] rdMux;
   always_comb begin
      case (paddr)
         `DIF_CTRL: rdMux = {28'h0000000, ctrl_reg};
         `DIF_PCFG: rdMux = {29'h00000000, pfun_reg};
         `DIF_PMAX: rdMux = {16'h0000, pMax_reg};
         `DIF_CNTV: rdMux = {16'h0000, cntVal_reg};
         `DIF_AFUN: rdMux = {28'h0000000, afun_reg};
         `DIF_AMIN: rdMux = {16'h0000, aMin_reg};
         `DIF_AMAX: rdMux = {16'h0000, aMax_reg};
         `DIF_WOBD: rdMux = {16'h0000, wobD_reg};
         `DIF_CATP: rdMux = {24'h000000, catPct_reg};
         `DIF_REFH: rdMux = {16'h0000, refHeld};
         `DIF_FRQH: rdMux = {16'h0000, freqHeld};
         `DIF_STAT: rdMux = {posCnt_reg, 9'h000, cntHalt_reg, setupIdx,
                             presetIdx, rampSet2, haltReq};
         `DIF_AOUT: rdMux = {16'h0000, ainFrac_reg};
         `DIF_POUT: rdMux = {16'h0000, pulseFrac_reg};
         default: rdMux = 32'h00000000;
      endcase
   end

   // One wait state: pready rises in the second access cycle
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= access & ~pready;
         pslverr <= access & ~pready & ~mapped;
         prdata <= (access & ~pready & ~pwrite) ? rdMux : 32'h00000000;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctrl_reg <= 4'h0;
         pfun_reg <= dif_pkg::DIF_P_OFF;
         afun_reg <= dif_pkg::DIF_AIN_OFF;
         pMax_reg <= `DIF_RST_PMAX;
         cntVal_reg <= 16'h0000;
         aMin_reg <= 16'h0000;
         aMax_reg <= `DIF_RST_AMAX;
         wobD_reg <= 16'h0000;
         catPct_reg <= 8'h00;
      end else if (wrEn) begin
         case (paddr)
            `DIF_CTRL: ctrl_reg <= pwdata[3:0];
            `DIF_PCFG: pfun_reg <= dif_pkg::dif_pfun_t'(pwdata[2:0]);
            `DIF_PMAX: pMax_reg <= pwdata[15:0];
            `DIF_CNTV: cntVal_reg <= pwdata[15:0];
            `DIF_AFUN: afun_reg <= dif_pkg::dif_ain_t'(pwdata[3:0]);
            `DIF_AMIN: aMin_reg <= pwdata[15:0];
            `DIF_AMAX: aMax_reg <= pwdata[15:0];
            `DIF_WOBD: wobD_reg <= pwdata[15:0];
            `DIF_CATP: catPct_reg <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // ****************************************
   // Input synchronisers and millisecond base
   // ****************************************
   logic [17:0] syncA_reg, syncB_reg, prev_reg;
   logic [13:0] msCnt_reg;
   wire msTick = msCnt_reg == MS_LAST;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         // Idle levels, so no stop pulse or false edge follows reset
         syncA_reg <= `DIF_IN_IDLE;
         syncB_reg <= `DIF_IN_IDLE;
         prev_reg <= `DIF_IN_IDLE;
         msCnt_reg <= 14'h0000;
      end else begin
         syncA_reg <= dIn;
         syncB_reg <= syncA_reg;
         prev_reg <= syncB_reg;
         msCnt_reg <= msTick ? 14'h0000 : msCnt_reg + 14'h0001;
      end
   end
   wire aRise = syncB_reg[`DIF_IN_TRKA] & ~prev_reg[`DIF_IN_TRKA];
   wire rsRise = syncB_reg[`DIF_IN_RSTART] & ~prev_reg[`DIF_IN_RSTART];

   // ****************************************
   // Up/down pulse qualifiers (0 = inc, 1 = dec)
   // ****************************************
   logic [4:0] hiMs_reg [2];
   logic [4:0] loMs_reg [2];
   logic [1:0] arm_reg, udPulse_reg;
   for (genvar k = 0; k < 2; k++) begin : g_qual
      wire lvl = syncB_reg[`DIF_IN_INC + k];
      always_ff @(posedge clk or posedge reset) begin
         if (reset) begin
            hiMs_reg[k] <= 5'h00;
            loMs_reg[k] <= 5'h00;
            arm_reg[k] <= 1'b0;
            udPulse_reg[k] <= 1'b0;
         end else if (lvl) begin
            loMs_reg[k] <= 5'h00;
            udPulse_reg[k] <= 1'b0;
            if (msTick && hiMs_reg[k] != THR) begin
               hiMs_reg[k] <= hiMs_reg[k] + 5'h01;
            end
         end else begin
            hiMs_reg[k] <= 5'h00;
            udPulse_reg[k] <= arm_reg[k] && loMs_reg[k] == THR;
            if (hiMs_reg[k] == THR) begin
               arm_reg[k] <= 1'b1;
            end else if (loMs_reg[k] == THR) begin
               arm_reg[k] <= 1'b0;
            end
            if (msTick && loMs_reg[k] != THR) begin
               loMs_reg[k] <= loMs_reg[k] + 5'h01;
            end
         end
      end
   end

   // ****************************************
   // Held reference and held output frequency
   // ****************************************
   wire decLvl = syncB_reg[`DIF_IN_DEC];
   wire stepDn = udPulse_reg[1] | (udPulse_reg[0] & decLvl);
   wire stepUp = udPulse_reg[0] & ~decLvl & ~udPulse_reg[1];
   wire refUp = frzRef & stepUp & refHeld < `DIF_REF_MAX;
   wire refDn = frzRef & stepDn & refHeld != 16'h0000;
   wire frqUp = frzOut & stepUp & freqHeld != 16'hffff;
   wire frqDn = frzOut & stepDn & freqHeld != 16'h0000;
   // Held reference is reloaded by software after a mains loss
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         refHeld <= 16'h0000;
         freqHeld <= 16'h0000;
      end else begin
         if (refWr) begin
            refHeld <= pwdata[15:0];
         end else if (refUp | refDn) begin
            refHeld <= refUp ? refHeld + 16'h0001 : refHeld - 16'h0001;
         end
         if (frqWr) begin
            freqHeld <= pwdata[15:0];
         end else if (frqUp | frqDn) begin
            freqHeld <= frqUp ? freqHeld + 16'h0001 : freqHeld - 16'h0001;
         end
      end
   end

   // ****************************************
   // Pulse, encoder and counter inputs
   // ****************************************
   wire encMode = pfun_reg == dif_pkg::DIF_P_EREF ||
                  pfun_reg == dif_pkg::DIF_P_EFB ||
                  pfun_reg == dif_pkg::DIF_P_ECNT;
   wire cntMode = pfun_reg == dif_pkg::DIF_P_PCNT ||
                  pfun_reg == dif_pkg::DIF_P_ECNT;
   wire dirDn = encMode & syncB_reg[`DIF_IN_TRKB];
   wire signed [15:0] posNext = dirDn ? posCnt_reg - 16'sh0001
                                      : posCnt_reg + 16'sh0001;
   wire cntHit = cntMode && aRise && cntVal_reg != 16'h0000 &&
                 posNext == $signed(cntVal_reg);
   logic [7:0] gateMs_reg;
   logic [15:0] edgeCnt_reg, pulseHz_reg;
   wire gateEnd = msTick && gateMs_reg == `DIF_GATE_MS - 8'h01;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         posCnt_reg <= 16'sh0000;
         cntHalt_reg <= 1'b0;
      end else begin
         if (cntWr) begin
            posCnt_reg <= 16'sh0000;
         end else if (cntMode && aRise) begin
            posCnt_reg <= posNext;
         end
         // A hit in the clearing cycle still raises the halt
         cntHalt_reg <= cntHit | (cntHalt_reg & ~cntWr);
      end
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         gateMs_reg <= 8'h00;
         edgeCnt_reg <= 16'h0000;
         pulseHz_reg <= 16'h0000;
      end else begin
         if (msTick) begin
            gateMs_reg <= gateEnd ? 8'h00 : gateMs_reg + 8'h01;
         end
         if (gateEnd) begin
            edgeCnt_reg <= {15'h0000, aRise};
            pulseHz_reg <= sat16(17'(edgeCnt_reg * HZ_MUL));
         end else if (aRise && edgeCnt_reg != 16'h1999) begin
            edgeCnt_reg <= edgeCnt_reg + 16'h0001;
         end
      end
   end

   // ****************************************
   // Shared serial divider: fraction num/den in Q16
   // ****************************************
   dif_pkg::dif_div_t divSt_reg;
   logic job_reg;
   logic [16:0] rem_reg;
   logic [15:0] quo_reg, den_reg;
   logic [4:0] bit_reg;
   wire [15:0] aNum = ({2'b00, ainMv} > aMin_reg) ?
                      {2'b00, ainMv} - aMin_reg : 16'h0000;
   wire [15:0] aDen = aMax_reg > aMin_reg ? aMax_reg - aMin_reg : 16'h0000;
   wire [15:0] num = job_reg ? pulseHz_reg : aNum;
   wire [15:0] den = job_reg ? pMax_reg : aDen;
   wire [16:0] remSh = {rem_reg[15:0], 1'b0};
   wire remGe = remSh >= {1'b0, den_reg};
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         divSt_reg <= dif_pkg::DIF_D_IDLE;
         job_reg <= 1'b0;
         rem_reg <= 17'h00000;
         quo_reg <= 16'h0000;
         den_reg <= 16'h0000;
         bit_reg <= 5'h00;
      end else begin
         case (divSt_reg)
            dif_pkg::DIF_D_IDLE: begin
               den_reg <= den;
               rem_reg <= {1'b0, num};
               bit_reg <= 5'h10;
               quo_reg <= (den == 16'h0000) ? 16'h0000 : 16'hffff;
               divSt_reg <= (den != 16'h0000 && num < den) ?
                            dif_pkg::DIF_D_RUN : dif_pkg::DIF_D_DONE;
            end
            dif_pkg::DIF_D_RUN: begin
               rem_reg <= remGe ? remSh - {1'b0, den_reg} : remSh;
               quo_reg <= {quo_reg[14:0], remGe};
               bit_reg <= bit_reg - 5'h01;
               if (bit_reg == 5'h01) begin
                  divSt_reg <= dif_pkg::DIF_D_DONE;
               end
            end
            dif_pkg::DIF_D_DONE: begin
               job_reg <= ~job_reg;
               divSt_reg <= dif_pkg::DIF_D_IDLE;
            end
            default: divSt_reg <= dif_pkg::DIF_D_IDLE;
         endcase
      end
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ainFrac_reg <= 16'h0000;
         pulseFrac_reg <= 16'h0000;
      end else if (divSt_reg == dif_pkg::DIF_D_DONE) begin
         if (job_reg) begin
            pulseFrac_reg <= quo_reg;
         end else begin
            ainFrac_reg <= quo_reg;
         end
      end
   end

   // ****************************************
   // Command and reference outputs
   // ****************************************
   wire pRef = pfun_reg == dif_pkg::DIF_P_PREF ||
               pfun_reg == dif_pkg::DIF_P_EREF;
   wire pFb = pfun_reg == dif_pkg::DIF_P_PFB ||
              pfun_reg == dif_pkg::DIF_P_EFB;
   wire aRef = afun_reg == dif_pkg::DIF_AIN_REF;
   wire aFb = afun_reg == dif_pkg::DIF_AIN_FB;
   wire aWob = afun_reg == dif_pkg::DIF_AIN_WOB;
   // Weight by fraction plus one so a full input yields the whole delta
   wire [31:0] wobProd = ainFrac_reg * wobD_reg + {16'h0000, wobD_reg};
   assign haltReq = ~syncB_reg[`DIF_IN_HALT] | cntHalt_reg;
   wire stopReq = ~syncB_reg[`DIF_IN_STOP] & ~frzOut;
   wire catchLvl = syncB_reg[`DIF_IN_CATCH];
   wire slowLvl = syncB_reg[`DIF_IN_SLOW];
   wire signed [8:0] pct = $signed({1'b0, catPct_reg});
   wire signed [8:0] trimNext = slowLvl ? -pct : (catchLvl ? pct : 9'sh000);
   wire [1:0] setupPins = {syncB_reg[`DIF_IN_SMSB], syncB_reg[`DIF_IN_SLSB]};
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         coastCmd <= 1'b0;
         quickCmd <= 1'b0;
         dcBrakeCmd <= 1'b0;
         rampStopCmd <= 1'b0;
         rampSet2 <= 1'b0;
         presetIdx <= 2'b00;
         usePreset <= 1'b0;
         setupIdx <= 2'b00;
         alarmReset <= 1'b0;
         runPreset <= 1'b0;
         refTrim <= 9'sh000;
      end else begin
         coastCmd <= ~syncB_reg[`DIF_IN_COAST];
         quickCmd <= ~syncB_reg[`DIF_IN_QUICK];
         dcBrakeCmd <= ~syncB_reg[`DIF_IN_DCBRK];
         rampStopCmd <= stopReq | haltReq;
         rampSet2 <= syncB_reg[`DIF_IN_RAMP] | frzOut;
         presetIdx <= {syncB_reg[`DIF_IN_PMSB],
                       syncB_reg[`DIF_IN_PLSB]};
         usePreset <= ctrl_reg[`DIF_B_EXTPRE] &
                      syncB_reg[`DIF_IN_PON];
         setupIdx <= ctrl_reg[`DIF_B_MULTI] ? setupPins : setupIdx;
         alarmReset <= rsRise;
         runPreset <= syncB_reg[`DIF_IN_RSTART];
         refTrim <= trimNext;
      end
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         refSum <= 17'h00000;
         feedback <= 16'h0000;
         wobbleOut <= 16'h0000;
      end else begin
         refSum <= (aRef ? {1'b0, ainFrac_reg} : 17'h00000) +
                   (pRef ? {1'b0, pulseFrac_reg} : 17'h00000);
         feedback <= aFb ? ainFrac_reg :
                     (pFb ? pulseFrac_reg : 16'h0000);
         wobbleOut <= aWob ? wobProd[31:16] : 16'h0000;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   sequence rs_pulse;
      alarmReset ##1 !alarmReset;
   endsequence
   sequence halt_seen;
      cntHalt_reg ##1 rampStopCmd;
   endsequence
   stop_hold_a: assert property (frzOut && syncB_reg[`DIF_IN_HALT] &&
      !cntHalt_reg |=> !rampStopCmd) else $error("stop not held");
   ud_gate_a: assert property (!frzRef && !refWr |=>
      $stable(refHeld)) else $error("held reference moved");
   ud_down_a: assert property (frzRef && !refWr && udPulse_reg[1] &&
      refHeld != 16'h0000 |=> refHeld == $past(refHeld) - 16'h0001)
      else $error("decrement lost");
   ramp_two_a: assert property (frzOut |=> rampSet2)
      else $error("hold not on ramp two");
   pulse_len_a: assert property ($rose(udPulse_reg[0]) |->
      !syncB_reg[`DIF_IN_INC] && loMs_reg[0] == THR)
      else $error("short pulse accepted");
   preset_a: assert property (!ctrl_reg[`DIF_B_EXTPRE] |=>
      !usePreset) else $error("preset outside preset mode");
   setup_a: assert property (!ctrl_reg[`DIF_B_MULTI] |=>
      $stable(setupIdx)) else $error("setup changed");
   rs_start_a: assert property (rsRise |=> rs_pulse)
      else $error("alarm reset not one cycle");
   cnt_halt_a: assert property (cntHit && !reset |=> halt_seen)
      else $error("count did not halt");
   trim_a: assert property (slowLvl |=> refTrim == -$past(pct))
      else $error("slow-down trim wrong");
   wob_off_a: assert property (!aWob |=> wobbleOut == 16'h0000)
      else $error("wobble leak");
endmodule
`default_nettype wire

/* bench/dif_switch_model.sv */
// Model of the switches and controller that drive the input pins
`timescale 1ns/1ps
`default_nettype none
module dif_switch_model #(
   parameter int MS_CYCLES = 10
) (
   input wire logic clk,
   output logic [17:0] dIn
);
   // Stop-type pins and the accurate halt pin rest high, the rest rest low
   initial dIn = 18'h0100f;
   task setPins(input logic [17:0] mask, input logic [17:0] val);
      @(posedge clk);
      dIn <= (dIn & ~mask) | (val & mask);
   endtask
   task press(input logic [17:0] mask, input int hiMs, input int loMs);
      @(posedge clk);
      dIn <= dIn | mask;
      repeat (hiMs * MS_CYCLES) @(posedge clk);
      dIn <= dIn & ~mask;
      repeat (loMs * MS_CYCLES) @(posedge clk);
   endtask
endmodule
`default_nettype wire

/* bench/tb_drive_input_function_decoder.sv */
// Self-checking bench for the digital input function decoder
`timescale 1ns/1ps
`default_nettype none
`include "dif_map.svh"
module tb_drive_input_function_decoder;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [13:0] ainMv = 14'h0;
   wire [31:0] prdata;
   wire pready, pslverr, coastCmd, quickCmd, dcBrakeCmd, rampStopCmd;
   wire rampSet2, usePreset, alarmReset, runPreset;
   wire [1:0] presetIdx, setupIdx;
   wire [15:0] refHeld, freqHeld, feedback, wobbleOut;
   wire signed [8:0] refTrim;
   wire [16:0] refSum;
   wire [17:0] dIn;
   int n_mismatch = 0;
   int n_compared = 0;
   int seed = 61485;
   int i, k;
   logic [31:0] rd, r;
   logic er;
   logic [7:0] p;
   logic [1:0] sExp = 2'b00;
   always #50 clk = ~clk;
   dif_switch_model #(.MS_CYCLES(10)) sw (.clk(clk), .dIn(dIn));
   dif_decoder #(.MS_CYCLES(10)) dut (.clk(clk), .reset(reset),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .dIn(dIn), .ainMv(ainMv), .coastCmd(coastCmd),
      .quickCmd(quickCmd), .dcBrakeCmd(dcBrakeCmd),
      .rampStopCmd(rampStopCmd), .rampSet2(rampSet2),
      .presetIdx(presetIdx), .usePreset(usePreset), .setupIdx(setupIdx),
      .alarmReset(alarmReset), .runPreset(runPreset), .refHeld(refHeld),
      .freqHeld(freqHeld), .refTrim(refTrim), .refSum(refSum),
      .feedback(feedback), .wobbleOut(wobbleOut));
   // ****************************************
   // Checking and bus tasks
   // ****************************************
   function logic [8:0] trimExp(input logic c, s, input logic [7:0] v);
      trimExp = s ? -{1'b0, v} : (c ? {1'b0, v} : 9'h000);
   endfunction
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task settle;
      repeat (5) @(posedge clk);
   endtask
   task close_out;
      $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      close_out;
   end
   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      settle;
      chk({coastCmd, quickCmd, dcBrakeCmd, rampStopCmd}, 0);
      apb(1'b0, `DIF_AMAX, 0);
      chk(rd, `DIF_RST_AMAX);
      apb(1'b0, `DIF_PMAX, 0);
      chk(rd, `DIF_RST_PMAX);
      apb(1'b0, 8'h38, 0);
      chk({rd[0], er}, 2'b01);
      $display("Test registers done");
      apb(1'b1, `DIF_REFH, 32'h000001f4);
      sw.press(18'h10, 16, 16);
      settle;
      chk(refHeld, 500);
      apb(1'b1, `DIF_CTRL, 32'h1);
      sw.press(18'h10, 16, 16);
      settle;
      chk(refHeld, 501);
      sw.press(18'h30, 16, 16);
      settle;
      chk(refHeld, 500);
      sw.press(18'h20, 5, 16);
      settle;
      chk(refHeld, 500);
      apb(1'b1, `DIF_CTRL, 32'h2);
      sw.press(18'h10, 14, 16);
      settle;
      chk(freqHeld, 1);
      $display("Test speed steps done");
      sw.setPins(18'h8, 18'h0);
      settle;
      chk({rampStopCmd, rampSet2}, 2'b01);
      for (i = 0; i < 3; i++) begin
         sw.setPins(18'h7, ~(18'h1 << i));
         settle;
         chk({dcBrakeCmd, quickCmd, coastCmd}, 3'b001 << i);
      end
      sw.setPins(18'h7, 18'h7);
      apb(1'b1, `DIF_CTRL, 32'h0);
      settle;
      chk({rampStopCmd, rampSet2}, 2'b10);
      sw.setPins(18'h1008, 18'h0008);
      settle;
      chk(rampStopCmd, 1);
      sw.setPins(18'h1008, 18'h1008);
      sw.setPins(18'h8000, 18'h8000);
      k = 0;
      while (alarmReset !== 1'b1 && k < 10) begin
         @(posedge clk);
         k++;
      end
      chk(alarmReset, 1);
      @(posedge clk);
      chk({alarmReset, runPreset}, 2'b01);
      sw.setPins(18'h8000, 18'h0);
      $display("Test stops done");
      for (i = 0; i < 12; i++) begin
         r = $random(seed);
         if (i == 0) r = 32'h00030fc0;
         p = r[31:24] % 8'd101;
         apb(1'b1, `DIF_CATP, {24'h0, p});
         apb(1'b1, `DIF_CTRL, {28'h0, r[17], r[16], 2'b00});
         sw.setPins(18'h06fc0, r[17:0]);
         settle;
         if (r[16]) sExp = r[14:13];
         chk({23'h0, refTrim}, {23'h0, trimExp(r[6], r[7], p)});
         chk({rampSet2, presetIdx}, {r[8], r[10:9]});
         chk(usePreset, r[11] & r[17]);
         chk(setupIdx, sExp);
      end
      $display("Test random pins done");
      apb(1'b1, `DIF_PCFG, 32'h00000006);
      apb(1'b1, `DIF_CNTV, 32'h00000002);
      sw.press(18'h10000, 1, 1);
      chk(rampStopCmd, 0);
      sw.press(18'h10000, 1, 1);
      settle;
      chk(rampStopCmd, 1);
      apb(1'b1, `DIF_CNTV, 32'h00000000);
      sw.setPins(18'h20000, 18'h20000);
      sw.press(18'h10000, 1, 1);
      apb(1'b0, `DIF_STAT, 0);
      chk({rd[31:16], rd[6]}, 17'h1fffe);
      sw.setPins(18'h20000, 18'h0);
      $display("Test counter done");
      ainMv <= 14'h2710;
      apb(1'b1, `DIF_AFUN, 32'h0);
      repeat (100) @(posedge clk);
      chk({feedback, wobbleOut}, 0);
      apb(1'b1, `DIF_AFUN, 32'h2);
      repeat (100) @(posedge clk);
      chk(feedback, 16'hffff);
      apb(1'b1, `DIF_AFUN, 32'h1);
      repeat (100) @(posedge clk);
      chk(refSum, 17'h0ffff);
      apb(1'b1, `DIF_AMIN, 32'h000007d0);
      ainMv <= 14'h1770;
      repeat (100) @(posedge clk);
      chk(refSum, 17'h08000);
      apb(1'b1, `DIF_WOBD, 32'h00000064);
      apb(1'b1, `DIF_AFUN, 32'h0000000a);
      repeat (100) @(posedge clk);
      chk({refSum[15:0], wobbleOut}, 32'h00000032);
      ainMv <= 14'h2710;
      repeat (100) @(posedge clk);
      chk(wobbleOut, 16'h0064);
      $display("Test analogue done");
      close_out;
   end
endmodule
`default_nettype wire
